/* File: bench/rcs_board_model.sv */
// Purpose: Board model: power-on source and pulled-up hard reset line.
// Assumes: Bench requests change just after a rising edge.
// Notes: Power-on hold runs four cycles over the minimum for margin.
`timescale 1ns/1ps
module rcs_board_model
   import rcs_pkg::*;
(
   // Bench requests
   input wire logic clk,
   input wire logic por_req,
   input wire logic pin_pull,
   // Device pins
   input wire logic hard_reset_n_out,
   input wire logic hard_reset_n_oe,
   output logic rstn,
   output logic hard_reset_n_in
);
   // --------------
   // Reset and line
   // --------------
   int hold_q = POR_MIN_CYCLES + 4;
   always @(posedge clk)
   begin
      hold_q <= por_req ? POR_MIN_CYCLES + 4 : hold_q - (hold_q != 0);
   end
   assign rstn = (hold_q == 0);
   assign hard_reset_n_in = (hard_reset_n_oe ? hard_reset_n_out : 1'h1) && !pin_pull;
endmodule : rcs_board_model

/* File: bench/rcs_reset_ctrl_bench.sv */
// Purpose: Self-checking bench for the reset controller.
// Assumes: Release count shortened to 20 cycles.
// Notes: Each reset source runs to completion before the next.
`timescale 1ns/1ps
module rcs_reset_ctrl_bench;
   import rcs_pkg::*;
   // -------
   // Signals
   // -------
   logic clk = 1'h0;
   logic rstn, pin_in, pin_out, pin_oe, soft_reset_n, system_reset_n, avs_waitrequest;
   logic [6:0] stim = 7'h00;
   logic [4:0] pins = 5'h16;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic synth_n;
   rcs_boot_cfg_t boot_pins;
   logic [6:0] c_mul [4] = '{7'h02, 7'h1a, 7'h34, 7'h13};
   logic [31:0] ctl_q = CLOCK_CONTROL_RESET;
   logic [31:0] cfg_q = 32'h16;
   logic [6:0] t_s [8] = '{7'h00, 7'h20, 7'h18, 7'h06, 7'h01, 7'h10, 7'h19, 7'h40};
   logic [31:0] t_st [8] = '{32'h10, 32'h08, 32'h04, 32'h02, 32'h01, 32'h01, 32'h04, 32'h10};
   logic [1:0] t_sv [8] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h0, 2'h2, 2'h2};
   logic [4:0] c_div [4] = '{5'h00, 5'h09, 5'h1f, 5'h04};
   int mismatches = 0;
   int checks = 0;
   initial forever #5 clk = ~clk;
   rcs_board_model i_board (.clk(clk), .por_req(stim[6]), .pin_pull(stim[5]), .hard_reset_n_out(pin_out),
      .hard_reset_n_oe(pin_oe), .rstn(rstn), .hard_reset_n_in(pin_in));
   rcs_reset_ctrl #(.RELEASE_CYCLES(20)) i_dut (.clk(clk), .rstn(rstn), .hard_reset_n_in(pin_in),
      .hard_reset_n_out(pin_out), .hard_reset_n_oe(pin_oe), .watchdog_expired(stim[4]),
      .watchdog_event_en(stim[3]), .bus_monitor_expired(stim[2]), .bus_monitor_event_en(stim[1]),
      .test_boundary_cmd(stim[0]), .boot_select(pins[4:3]), .watchdog_boot_enable(pins[2]),
      .host_byte_width(pins[1]), .host_config_select(pins[0]), .soft_reset_n(soft_reset_n),
      .system_reset_n(system_reset_n), .clock_synth_reset_n(synth_n), .boot_cfg(boot_pins),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   // -----
   // Tasks
   // -----
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   task automatic limit(input int n);
      if (n >= 200)
      begin
         mismatches++;
         $display("[FAIL] %0t wait ran out", $time);
         end_sim();
      end
   endtask : limit
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'h0 && n < 200);
      rd = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      limit(n);
   endtask : bus
   // Waits out the whole flow; a flow that never ends hits the bound.
   task automatic fire(input logic [6:0] s, output logic [1:0] sv);
      int n;
      sv = 2'h0;
      @(posedge clk);
      stim <= s;
      @(posedge clk);
      stim <= 7'h00;
      n = 0;
      do
      begin
         @(posedge clk);
         sv = sv | {pin_oe, !soft_reset_n};
         n++;
      end
      while ((!rstn || !system_reset_n || !soft_reset_n) && n < 200);
      limit(n);
   endtask : fire
   task automatic clocks();
      logic [31:0] rd;
      logic [31:0] w;
      logic [4:0] dc;
      for (int i = 0; i < 4; i++)
      begin
         dc = (c_div[i] > DIVIDER_MAX_CODE) ? DIVIDER_MAX_CODE : c_div[i];
         // Loop stays in 266 to 532 MHz, core at or below 300 MHz, no external memory.
         w = {10'h0, i < 2, 1'h1, 3'h0, !i[0], 1'h0, c_mul[i], 3'h0, c_div[i]};
         bus(1'h1, REG_CLOCK_CONTROL, w, rd);
         bus(1'h0, REG_CLOCK_CONTROL, 32'h0, rd);
         chk(rd, {w[31:5], dc});
         bus(1'h0, REG_CLOCK_DIVIDE, 32'h0, rd);
         chk(rd, {13'h0, 3'h1 << (2'(w[21:20] == SRC_VCO_HALF) + 2'(!w[16])), {1'h0, w[14:8]} + 8'h01, 3'h0,
                  dc + 5'h01});
      end
      w = {10'h0, SRC_REFERENCE, 3'h0, 1'h1, 16'h0200};
      bus(1'h1, REG_CLOCK_CONTROL, w, rd);
      bus(1'h0, REG_CLOCK_DIVIDE, 32'h0, rd);
      chk({31'h0, rd[19]}, 32'h1);
      ctl_q = w;
      bus(1'h1, 4'h2, 32'hffff_ffff, rd);
      bus(1'h0, 4'h2, 32'h0, rd);
      chk(rd, BUS_UNMAPPED_DATA);
      pins <= 5'h09;
   endtask : clocks
   // ---------
   // Sequence
   // ---------
   initial
   begin
      logic [31:0] rd;
      logic [1:0] sv;
      for (int k = 0; k < 8; k++)
      begin
         fire(t_s[k], sv);
         chk({30'h0, sv}, {30'h0, t_sv[k]});
         bus(1'h0, REG_RESET_STATUS, 32'h0, rd);
         chk(rd, t_st[k]);
         if (t_s[k][6])
         begin
            cfg_q = 32'h09;
            ctl_q = CLOCK_CONTROL_RESET;
         end
         bus(1'h0, REG_BOOT_CONFIG, 32'h0, rd);
         chk(rd, cfg_q);
         chk({27'h0, boot_pins}, cfg_q);
         chk({31'h0, synth_n}, 32'h1);
         bus(1'h0, REG_CLOCK_CONTROL, 32'h0, rd);
         chk(rd, ctl_q);
         if (k == 0)
            clocks();
      end
      end_sim();
   end
endmodule : rcs_reset_ctrl_bench

/* File: bench/rcs_reset_props.sv */
// Purpose: Port checks for the reset controller.
// Assumes: One clock; rstn is the power-on reset.
// Notes: The power-on hold may run one cycle long.
`timescale 1ns/1ps
module rcs_reset_props
   import rcs_pkg::*;
#(
   parameter int RELEASE_CYCLES = HRST_RELEASE_CYCLES
)
(
   // Clock, reset and pin
   input wire logic clk,
   input wire logic rstn,
   input wire logic hard_reset_n_in,
   input wire logic hard_reset_n_oe,
   // Sources
   input wire logic watchdog_expired,
   input wire logic watchdog_event_en,
   input wire logic bus_monitor_expired,
   input wire logic bus_monitor_event_en,
   input wire logic test_boundary_cmd,
   // Results
   input wire logic soft_reset_n,
   input wire logic system_reset_n,
   input wire logic clock_synth_reset_n,
   input wire rcs_boot_cfg_t boot_cfg
);
   // ------
   // Checks
   // ------
   localparam int R = RELEASE_CYCLES;
   int hold_q;
   wire wd_req = watchdog_expired && watchdog_event_en;
   wire bm_req = bus_monitor_expired && bus_monitor_event_en;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   always_ff @(posedge clk)
   begin
      hold_q <= (rstn && hard_reset_n_oe) ? hold_q + 1 : 0;
   end
   pin_hold_a: assert property ($fell(hard_reset_n_oe) |-> hold_q >= R && hold_q <= R + 1)
      else $error("pin hold wrong");
   cfg_keep_a: assert property ($past(rstn) && $past(rstn, 2) |-> $stable(boot_cfg))
      else $error("config changed");
   soft_pin_a: assert property ($fell(soft_reset_n) |-> !hard_reset_n_oe)
      else $error("pin driven in soft flow");
   ext_go_a: assert property (!hard_reset_n_in && !hard_reset_n_oe && system_reset_n |=> hard_reset_n_oe)
      else $error("pin request ignored");
   wd_go_a: assert property (wd_req && system_reset_n |=> hard_reset_n_oe && !system_reset_n)
      else $error("watchdog ignored");
   bm_go_a: assert property (bm_req && system_reset_n |=> hard_reset_n_oe && !system_reset_n)
      else $error("bus monitor ignored");
   soft_go_a: assert property (test_boundary_cmd && system_reset_n && hard_reset_n_in
      && !wd_req && !bm_req |=> !soft_reset_n && !system_reset_n) else $error("soft request ignored");
   pin_sys_a: assert property ($fell(hard_reset_n_oe) |-> $rose(system_reset_n))
      else $error("core reset not with pin");
   hard_first_a: assert property (wd_req && test_boundary_cmd && system_reset_n |=> soft_reset_n)
      else $error("soft beat hard");
   synth_keep_a: assert property ($past(rstn) |-> clock_synth_reset_n)
      else $error("clock state reset outside power-on");
   synth_low_a: assert property (@(posedge clk) disable iff (1'b0)
      !$past(rstn) |-> !clock_synth_reset_n) else $error("clock state kept through power-on");
endmodule : rcs_reset_props
bind rcs_reset_ctrl rcs_reset_props #(.RELEASE_CYCLES(RELEASE_CYCLES)) i_props (.clk(clk), .rstn(rstn),
   .hard_reset_n_in(hard_reset_n_in), .hard_reset_n_oe(hard_reset_n_oe), .watchdog_expired(watchdog_expired),
   .watchdog_event_en(watchdog_event_en), .bus_monitor_expired(bus_monitor_expired),
   .bus_monitor_event_en(bus_monitor_event_en), .test_boundary_cmd(test_boundary_cmd),
   .soft_reset_n(soft_reset_n), .system_reset_n(system_reset_n),
   .clock_synth_reset_n(clock_synth_reset_n), .boot_cfg(boot_cfg));

/* File: rtl/rcs_clock_divide.sv */
// Purpose: Derives the input, loop and post clock division factors from the clock control word.
// Assumes: Clock control word is stable while it is read.
// Notes: Reports the ratio only; the analogue loop itself lives outside.
`timescale 1ns/1ps
module rcs_clock_divide
   import rcs_pkg::*;
(
   // Configuration
   input wire rcs_clock_control_word_t ctrl,
   // Result
   output logic [4:0] input_factor,
   output logic [7:0] loop_factor,
   output logic [2:0] post_factor,
   output logic use_reference
);

   assign input_factor = ctrl.loop_input_divider + 5'h01; // see RL13
   assign loop_factor = {1'b0, ctrl.loop_multiplier} + 8'h01;
   // Reference source bypasses the oscillator, so the post divider is one.
   assign use_reference = (ctrl.core_clock_source == SRC_REFERENCE); // see RL19
   assign post_factor = use_reference ? 3'h1 :
                        (ctrl.core_clock_source == SRC_VCO) ? (ctrl.vco_range_select ? 3'h1 : 3'h2) :
                        (ctrl.vco_range_select ? 3'h2 : 3'h4); // see RL15 see RL16

endmodule : rcs_clock_divide

/* File: rtl/rcs_pkg.sv */
// Purpose: Shared constants and types for the reset and clock setup controller.
// Assumes: One clock, clk, at 100 MHz, standing in for the reference clock.
// Notes: Register map sits on an Avalon-MM slave with waitrequest.
//
// Behaviour
// RL1: External party holds power-on reset sixteen cycles.
// RL2: Hard reset released 521 cycles after power-on.
// RL3: Capture five configuration levels at power-on release.
// RL4: Only power-on reset samples the configuration pins.
// RL5: Only power-on reset clears clock synthesis state.
// RL6: Drive hard reset pin for power-on and hard.
// RL7: Pin is open drain; external assertion starts hard.
// RL8: Enabled watchdog expiry launches internal hard reset.
// RL9: Enabled bus monitor expiry launches internal hard reset.
// RL10: Test port boundary commands start soft reset.
// RL11: Every flow resets watchdog, handshake, core, peripherals.
// RL12: Status record keeps sources of the latest reset.
// RL13: Input divider divides by field plus one.
// RL14: Software keeps loop frequency within 266 to 532.
// RL15: Range bit clear halves the loop frequency.
// RL16: Source code 11 and 01 give documented divisions.
// RL17: Software keeps core clock at or below 300.
// RL18: Software keeps core clock within memory limit.
// RL19: Core clock from reference, oscillator, or oscillator halved.
// RL20: Power-on beats hard, hard beats soft.
package rcs_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int POR_MIN_CYCLES = 16;
   localparam int HRST_RELEASE_CYCLES = 521;
   localparam int SOFT_HOLD_CYCLES = 16;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] REG_CLOCK_CONTROL = 4'h0;
   localparam logic [3:0] REG_RESET_STATUS = 4'h4;
   localparam logic [3:0] REG_BOOT_CONFIG = 4'h8;
   localparam logic [3:0] REG_CLOCK_DIVIDE = 4'hc;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int CLK_DIV_LSB = 0;
   localparam int CLK_MUL_LSB = 8;
   localparam int CLK_RNG_BIT = 16;
   localparam int CLK_SEL_LSB = 20;
   localparam logic [31:0] CLOCK_CONTROL_RESET = 32'h0000_0000;
   localparam logic [4:0] DIVIDER_MAX_CODE = 5'h09;
   localparam logic [1:0] SRC_REFERENCE = 2'h0;
   localparam logic [1:0] SRC_VCO_HALF = 2'h1;
   localparam logic [1:0] SRC_VCO = 2'h3;
   localparam logic [31:0] BUS_UNMAPPED_DATA = 32'h0000_0000;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic [6:0] loop_multiplier;
      logic [4:0] loop_input_divider;
      logic vco_range_select;
      logic [1:0] core_clock_source;
   } rcs_clock_control_word_t;

   typedef struct packed {
      logic [1:0] boot_select;
      logic watchdog_boot_enable;
      logic host_byte_width;
      logic host_config_select;
   } rcs_boot_cfg_t;

   typedef struct packed {
      logic power_on;
      logic hard_ext;
      logic watchdog;
      logic bus_monitor;
      logic soft_test;
   } rcs_rst_src_t;

   typedef enum logic [1:0] {RCS_RST_NONE, RCS_RST_SOFT, RCS_RST_HARD, RCS_RST_POR} rcs_flow_t;

endpackage : rcs_pkg

/* File: rtl/rcs_reset_ctrl.sv */
// Purpose: Reset sequencer with configuration capture and clock setup registers.
// Assumes: Reset sources are synchronous to clk; rstn is the power-on reset input.
// Notes: The hard reset pin is modelled as input, output and output enable.
`timescale 1ns/1ps
module rcs_reset_ctrl
   import rcs_pkg::*;
#(
   parameter int RELEASE_CYCLES = HRST_RELEASE_CYCLES
)
(
   // Clock and power-on reset
   input wire logic clk,
   input wire logic rstn,
   // Hard reset pin, open drain
   input wire logic hard_reset_n_in,
   output logic hard_reset_n_out,
   output logic hard_reset_n_oe,
   // Internal reset sources
   input wire logic watchdog_expired,
   input wire logic watchdog_event_en,
   input wire logic bus_monitor_expired,
   input wire logic bus_monitor_event_en,
   input wire logic test_boundary_cmd,
   // Configuration pins
   input wire logic [1:0] boot_select,
   input wire logic watchdog_boot_enable,
   input wire logic host_byte_width,
   input wire logic host_config_select,
   // Reset outputs
   output logic soft_reset_n,
   output logic system_reset_n,
   output logic clock_synth_reset_n,
   output rcs_boot_cfg_t boot_cfg,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   rcs_flow_t flow_q, flow_d;
   logic [9:0] count_q, count_d;
   logic por_done_q;
   rcs_boot_cfg_t boot_cfg_q;
   rcs_rst_src_t status_q, status_d;
   rcs_clock_control_word_t clk_ctrl_q;
   logic drive_q, soft_q, sys_q, synth_q;
   logic [31:0] rdata_q;
   logic ack_q;

   // ----------------------------------------
   // Source decode
   // ----------------------------------------
   wire wd_hit = watchdog_expired & watchdog_event_en; // see RL8
   wire bm_hit = bus_monitor_expired & bus_monitor_event_en; // see RL9
   // Only a low seen while the device is not driving counts as an external request.
   wire ext_hit = ~hard_reset_n_in & ~drive_q; // see RL7
   wire hard_req = wd_hit | bm_hit | ext_hit;
   wire soft_req = test_boundary_cmd; // see RL10
   wire [9:0] release_cnt = 10'(RELEASE_CYCLES - 1);
   wire [9:0] soft_cnt = 10'(SOFT_HOLD_CYCLES - 1);
   wire counting = (flow_q != RCS_RST_NONE);
   wire count_end = (count_q == 10'h000);

   always_comb
   begin
      flow_d = flow_q;
      count_d = counting && !count_end ? count_q - 10'h001 : count_q;
      status_d = status_q;
      if (!por_done_q)
      begin
         flow_d = RCS_RST_HARD;
         count_d = release_cnt;
      end
      else if (hard_req && flow_q != RCS_RST_HARD)
      begin
         // A hard request pre-empts a soft flow but never shortens a running hard one.
         flow_d = RCS_RST_HARD; // see RL20
         count_d = release_cnt;
         status_d = '{power_on: 1'b0, hard_ext: ext_hit, watchdog: wd_hit, bus_monitor: bm_hit, soft_test: 1'b0};
      end
      else if (soft_req && flow_q == RCS_RST_NONE)
      begin
         flow_d = RCS_RST_SOFT;
         count_d = soft_cnt;
         status_d = '{power_on: 1'b0, hard_ext: 1'b0, watchdog: 1'b0, bus_monitor: 1'b0, soft_test: 1'b1}; // see RL12
      end
      else if (counting && count_end)
      begin
         flow_d = RCS_RST_NONE;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         flow_q <= RCS_RST_POR;
         count_q <= 10'h000;
         por_done_q <= 1'b0;
         status_q <= '{power_on: 1'b1, default: 1'b0}; // see RL12
      end
      else
      begin
         por_done_q <= 1'b1;
         flow_q <= flow_d;
         count_q <= count_d; // see RL2
         status_q <= status_d;
      end
   end

   // Configuration is caught on the first edge after power-on release only.
   always_ff @(posedge clk)
   begin
      if (rstn && !por_done_q)
      begin
         boot_cfg_q <= '{boot_select, watchdog_boot_enable, host_byte_width, host_config_select}; // see RL3 see RL4
      end
   end

   // ----------------------------------------
   // Reset outputs
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         drive_q <= 1'b1;
         soft_q <= 1'b1; // see RL20
         sys_q <= 1'b0;
         synth_q <= 1'b0;
      end
      else
      begin
         drive_q <= (flow_d == RCS_RST_HARD); // see RL6
         soft_q <= ~(flow_d == RCS_RST_SOFT);
         sys_q <= (flow_d == RCS_RST_NONE); // see RL11
         synth_q <= 1'b1; // see RL5
      end
   end

   // ----------------------------------------
   // Clock control register
   // ----------------------------------------
   wire bus_req = (avs_read | avs_write) & ~ack_q;
   wire hit_ctrl = (avs_address == REG_CLOCK_CONTROL);
   wire hit_stat = (avs_address == REG_RESET_STATUS);
   wire hit_boot = (avs_address == REG_BOOT_CONFIG);
   wire hit_div = (avs_address == REG_CLOCK_DIVIDE);
   wire [4:0] div_in = avs_writedata[CLK_DIV_LSB +: 5];
   wire [4:0] div_ok = (div_in > DIVIDER_MAX_CODE) ? DIVIDER_MAX_CODE : div_in; // see RL13
   wire [4:0] in_fac;
   wire [7:0] loop_fac;
   wire [2:0] post_fac;
   wire use_ref;

   rcs_clock_divide u_div (
      .ctrl(clk_ctrl_q),
      .input_factor(in_fac),
      .loop_factor(loop_fac),
      .post_factor(post_fac),
      .use_reference(use_ref)
   );

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         clk_ctrl_q <= rcs_clock_control_word_t'(CLOCK_CONTROL_RESET[14:0]); // see RL5
      end
      else if (ack_q && avs_write && hit_ctrl)
      begin
         clk_ctrl_q <= '{avs_writedata[CLK_MUL_LSB +: 7], div_ok, avs_writedata[CLK_RNG_BIT],
                         avs_writedata[CLK_SEL_LSB +: 2]}; // see RL16
      end
   end

   wire [31:0] rd_ctrl = {10'h000, clk_ctrl_q.core_clock_source, 3'h0, clk_ctrl_q.vco_range_select,
                          1'b0, clk_ctrl_q.loop_multiplier, 3'h0, clk_ctrl_q.loop_input_divider};
   wire [31:0] rd_div = {12'h000, use_ref, post_fac, loop_fac, 3'h0, in_fac};
   wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                        hit_stat ? {27'h0000000, status_q} :
                        hit_boot ? {27'h0000000, boot_cfg_q} :
                        hit_div ? rd_div : BUS_UNMAPPED_DATA;

   // Each access stalls one cycle so read data come from a register.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= bus_req;
         rdata_q <= rd_mux;
      end
   end

   assign hard_reset_n_out = 1'b0; // see RL7
   assign hard_reset_n_oe = drive_q;
   assign soft_reset_n = soft_q;
   assign system_reset_n = sys_q;
   assign clock_synth_reset_n = synth_q;
   assign boot_cfg = boot_cfg_q;
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = ~ack_q;

endmodule : rcs_reset_ctrl
